// File: rtl/lpst_laser_power_startup_trip.sv
// Laser-current startup search, transmit power trips, signal-loss hysteresis
//
// Behaviour
// - Startup begins at power-on and again after each transmit-disable pulse.
// - While stepping, add twice the step size plus one until power feedback exceeds threshold.
// - First feedback exceedance switches stepping to a binary search finishing startup.
// - A step sum above the current ceiling is not loaded; binary search starts.
// - Current-ceiling alarm is suppressed throughout stepping.
// - Current-ceiling alarm detection is enabled only after binary search ends.
// - High threshold is power reference plus high adjust, clamped to 0xFF.
// - Raise power-high alarm when feedback exceeds high threshold voltage.
// - Low threshold is power reference minus low adjust, clamped to 0x00.
// - Raise power-low alarm when feedback is below low threshold voltage.
// - Received level below low threshold sets the signal-loss-low flag.
// - Low flag holds until level exceeds high threshold; then clear low, set high.
// - At power-on both loss flags are zero; comparator watches low threshold.
// - Below the control offset, reads need owner or granted user; writes need owner or user with read-write grant.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module lpst_laser_power_startup_trip
#(
    parameter int BIAS_W = 9 // Laser current setting width
)
(
    input wire logic core_clk, // 125 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [7:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic powerFeedbackAbove, // Feedback above startup threshold
    input wire logic [7:0] powerFeedbackCode, // Power feedback level as code
    input wire logic [7:0] receivedSignalLevel, // Received level as code
    output logic [7:0] regRdata, // Read data, cycle after strobe
    output logic [BIAS_W-1:0] laserCurrentSetting, // Bias setting to driver
    output logic startupDone, // Startup search finished
    output logic txPowerHighFlag, // Transmit power high alarm
    output logic txPowerLowFlag, // Transmit power low alarm
    output logic signalLossLowFlag, // Loss of signal low flag
    output logic signalLossHighFlag, // Loss of signal high flag
    output logic currentCeilingAlarm, // Current above ceiling alarm
    output logic irq // Level interrupt
);
    import lpst_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address decode for the register window shared by read and write
    function automatic logic inMap(input logic [7:0] a);
        inMap = (a >= OFF_RESERVED_SLOT && a <= OFF_LOS_LOW_THR)
            || (a >= OFF_CONTROL && a <= OFF_BIAS_HIGH);
    endfunction

    // Access grant for an address; control register always reachable
    function automatic logic allowed(input logic [7:0] a, input logic [7:0] c,
                                     input logic wr);
        if (a >= OFF_CONTROL)
            allowed = 1'b1;
        else if (wr)
            allowed = c[CTL_OWNER] || (c[CTL_USER] && c[CTL_RWGRANT]);
        else
            allowed = c[CTL_OWNER]
                || (c[CTL_USER] && (c[CTL_RWGRANT] || c[CTL_RGRANT]));
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] stepSize_ff, nxt_stepSize;
    logic [7:0] highAdj_ff, nxt_highAdj;
    logic [7:0] lowAdj_ff, nxt_lowAdj;
    logic [7:0] losHigh_ff, nxt_losHigh;
    logic [7:0] losLow_ff, nxt_losLow;
    logic [7:0] control_ff, nxt_control;
    logic [7:0] mask_ff, nxt_mask;
    logic [8:0] ceiling_ff, nxt_ceiling;
    logic [7:0] powerRef_ff, nxt_powerRef;
    logic [NUM_EVT-1:0] irqStat_ff, nxt_irqStat;
    logic [7:0] rdata_ff, nxt_rdata;
    logic done_ff, nxt_done;
    lpst_seq_e seq_ff, nxt_seq;
    logic [BIAS_W-1:0] bias_ff, nxt_bias;
    logic [BIAS_W-1:0] searchBit_ff, nxt_searchBit;
    logic [7:0] hiThr_ff, nxt_hiThr;
    logic [7:0] loThr_ff, nxt_loThr;
    logic txHi_ff, nxt_txHi;
    logic txLo_ff, nxt_txLo;
    logic losLo_ff, nxt_losLo;
    logic losHi_ff, nxt_losHi;
    logic ceilAlarm_ff, nxt_ceilAlarm;
    logic irq_ff, nxt_irq;

    // ------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------
    logic wrOk;
    logic rdOk;
    logic [NUM_EVT-1:0] events;
    logic [7:0] statusView;

    always_comb
    begin
        wrOk = regWr && inMap(regAddr) && allowed(regAddr, control_ff, 1'b1);
        rdOk = regRd && inMap(regAddr) && allowed(regAddr, control_ff, 1'b0);
        nxt_stepSize = stepSize_ff;
        nxt_highAdj = highAdj_ff;
        nxt_lowAdj = lowAdj_ff;
        nxt_losHigh = losHigh_ff;
        nxt_losLow = losLow_ff;
        nxt_control = control_ff;
        nxt_mask = mask_ff;
        nxt_ceiling = ceiling_ff;
        nxt_powerRef = powerRef_ff;
        // Reserved slot stores nothing and reads zero
        if (wrOk)
        begin
            case (regAddr)
                OFF_STARTUP_STEP: nxt_stepSize = regWdata;
                OFF_TXP_HIGH_ADJ: nxt_highAdj = regWdata;
                OFF_TXP_LOW_ADJ: nxt_lowAdj = regWdata;
                OFF_LOS_HIGH_THR: nxt_losHigh = regWdata;
                OFF_LOS_LOW_THR: nxt_losLow = regWdata;
                OFF_CONTROL: nxt_control = regWdata;
                OFF_IRQ_MASK: nxt_mask = regWdata;
                OFF_CURRENT_CEIL: nxt_ceiling = {regWdata, 1'b1};
                OFF_POWER_REF: nxt_powerRef = regWdata;
                default: ;
            endcase
        end
        statusView = {1'b0, 1'b0, ceilAlarm_ff, losHi_ff, losLo_ff, txLo_ff, txHi_ff, 1'b0};
        nxt_rdata = 8'h00;
        if (rdOk)
        begin
            case (regAddr)
                OFF_STARTUP_STEP: nxt_rdata = stepSize_ff;
                OFF_TXP_HIGH_ADJ: nxt_rdata = highAdj_ff;
                OFF_TXP_LOW_ADJ: nxt_rdata = lowAdj_ff;
                OFF_LOS_HIGH_THR: nxt_rdata = losHigh_ff;
                OFF_LOS_LOW_THR: nxt_rdata = losLow_ff;
                OFF_CONTROL: nxt_rdata = control_ff;
                OFF_STATUS: nxt_rdata = {statusView[7:1], seq_ff == SEQ_RUN};
                OFF_IRQ_STATUS: nxt_rdata = {1'b0, irqStat_ff};
                OFF_IRQ_MASK: nxt_rdata = mask_ff;
                OFF_CURRENT_CEIL: nxt_rdata = ceiling_ff[8:1];
                OFF_POWER_REF: nxt_rdata = powerRef_ff;
                OFF_BIAS_LOW: nxt_rdata = 8'(bias_ff);
                OFF_BIAS_HIGH: nxt_rdata = 8'(bias_ff >> 8);
                default: nxt_rdata = 8'h00; // Reserved slot reads zero
            endcase
        end
        // Sticky events: set wins over read-clear
        nxt_irqStat = irqStat_ff;
        if (rdOk && regAddr == OFF_IRQ_STATUS)
            nxt_irqStat = '0;
        nxt_irqStat = nxt_irqStat | events;
        nxt_irq = |(nxt_irqStat & mask_ff[NUM_EVT-1:0]);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stepSize_ff <= RST_REG8;
            highAdj_ff <= RST_REG8;
            lowAdj_ff <= RST_REG8;
            losHigh_ff <= RST_REG8;
            losLow_ff <= RST_REG8;
            control_ff <= RST_CONTROL;
            mask_ff <= RST_REG8;
            ceiling_ff <= RST_CEILING;
            powerRef_ff <= RST_REG8;
            irqStat_ff <= '0;
            rdata_ff <= RST_REG8;
            irq_ff <= 1'b0;
        end
        else
        begin
            stepSize_ff <= nxt_stepSize;
            highAdj_ff <= nxt_highAdj;
            lowAdj_ff <= nxt_lowAdj;
            losHigh_ff <= nxt_losHigh;
            losLow_ff <= nxt_losLow;
            control_ff <= nxt_control;
            mask_ff <= nxt_mask;
            ceiling_ff <= nxt_ceiling;
            powerRef_ff <= nxt_powerRef;
            irqStat_ff <= nxt_irqStat;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // Startup sequencer
    // ------------------------------------------------------------
    logic [BIAS_W:0] stepSum;
    logic [BIAS_W-1:0] trial;

    // Coarse stepping then successive approximation from the top bit down
    always_comb
    begin
        nxt_seq = seq_ff;
        nxt_bias = bias_ff;
        nxt_searchBit = searchBit_ff;
        stepSum = {1'b0, bias_ff} + {{(BIAS_W-8){1'b0}}, stepSize_ff, 1'b1};
        trial = bias_ff | searchBit_ff;
        case (seq_ff)
            SEQ_IDLE:
            begin
                nxt_bias = '0;
                if (!control_ff[CTL_TXDIS])
                    nxt_seq = SEQ_STEP;
            end
            SEQ_STEP:
            begin
                if (powerFeedbackAbove)
                begin
                    nxt_seq = SEQ_SEARCH;
                    nxt_bias = '0;
                    nxt_searchBit = {1'b1, {(BIAS_W-1){1'b0}}};
                end
                else if (stepSum > {1'b0, ceiling_ff})
                begin
                    nxt_seq = SEQ_SEARCH; // Sum not loaded
                    nxt_bias = '0;
                    nxt_searchBit = {1'b1, {(BIAS_W-1){1'b0}}};
                end
                else
                    nxt_bias = stepSum[BIAS_W-1:0];
            end
            SEQ_SEARCH:
            begin
                // Trial bit set last cycle: sample now, drop the bit if feedback is above
                if ((bias_ff & searchBit_ff) != '0)
                begin
                    if (powerFeedbackAbove)
                        nxt_bias = bias_ff & ~searchBit_ff;
                    nxt_searchBit = searchBit_ff >> 1;
                    if (searchBit_ff[0])
                        nxt_seq = SEQ_RUN;
                end
                else
                    nxt_bias = trial;
            end
            SEQ_RUN: ;
            default: nxt_seq = SEQ_IDLE;
        endcase
        // Transmit-disable pulse restarts the search on its falling edge
        if (control_ff[CTL_TXDIS])
            nxt_seq = SEQ_IDLE;
        nxt_done = (nxt_seq == SEQ_RUN);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            seq_ff <= SEQ_IDLE;
            bias_ff <= '0;
            searchBit_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            seq_ff <= nxt_seq;
            bias_ff <= nxt_bias;
            searchBit_ff <= nxt_searchBit;
            done_ff <= nxt_done;
        end
    end

    // ------------------------------------------------------------
    // Trips, loss hysteresis and ceiling alarm
    // ------------------------------------------------------------
    logic [8:0] hiSum;
    logic [8:0] loDiff;

    always_comb
    begin
        hiSum = {1'b0, powerRef_ff} + {1'b0, highAdj_ff};
        loDiff = {1'b0, powerRef_ff} - {1'b0, lowAdj_ff};
        nxt_hiThr = hiSum[8] ? CODE_MAX : hiSum[7:0];
        nxt_loThr = loDiff[8] ? CODE_MIN : loDiff[7:0];
        nxt_txHi = powerFeedbackCode > hiThr_ff;
        nxt_txLo = powerFeedbackCode < loThr_ff;
        nxt_losLo = losLo_ff;
        nxt_losHi = losHi_ff;
        // Comparator looks at the low threshold until the low flag is set
        if (!losLo_ff && receivedSignalLevel < losLow_ff)
        begin
            nxt_losLo = 1'b1;
            nxt_losHi = 1'b0;
        end
        else if (losLo_ff && receivedSignalLevel > losHigh_ff)
        begin
            nxt_losLo = 1'b0;
            nxt_losHi = 1'b1;
        end
        // The binary search may exceed the ceiling; only a settled loop may alarm
        nxt_ceilAlarm = (seq_ff == SEQ_RUN) && (bias_ff > ceiling_ff);
        events = '0;
        events[ST_TX_POWER_HIGH_FLAG] = nxt_txHi && !txHi_ff;
        events[ST_TX_POWER_LOW_FLAG] = nxt_txLo && !txLo_ff;
        events[ST_SIGNAL_LOSS_LOW_FLAG] = nxt_losLo && !losLo_ff;
        events[ST_SIGNAL_LOSS_HIGH_FLAG] = nxt_losHi && !losHi_ff;
        events[ST_CEIL] = nxt_ceilAlarm && !ceilAlarm_ff;
        events[ST_DONE] = nxt_seq == SEQ_RUN && seq_ff != SEQ_RUN;
        events[ST_DENIED] = (regWr || regRd) && inMap(regAddr) && !wrOk && !rdOk;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            hiThr_ff <= CODE_MAX;
            loThr_ff <= CODE_MIN;
            txHi_ff <= 1'b0;
            txLo_ff <= 1'b0;
            losLo_ff <= 1'b0;
            losHi_ff <= 1'b0;
            ceilAlarm_ff <= 1'b0;
        end
        else
        begin
            hiThr_ff <= nxt_hiThr;
            loThr_ff <= nxt_loThr;
            txHi_ff <= nxt_txHi;
            txLo_ff <= nxt_txLo;
            losLo_ff <= nxt_losLo;
            losHi_ff <= nxt_losHi;
            ceilAlarm_ff <= nxt_ceilAlarm;
        end
    end

    // Outputs straight from flip-flops
    assign regRdata = rdata_ff;
    assign laserCurrentSetting = bias_ff;
    assign startupDone = done_ff;
    assign txPowerHighFlag = txHi_ff;
    assign txPowerLowFlag = txLo_ff;
    assign signalLossLowFlag = losLo_ff;
    assign signalLossHighFlag = losHi_ff;
    assign currentCeilingAlarm = ceilAlarm_ff;
    assign irq = irq_ff;

endmodule

// File: inc/lpst_pkg.sv
// Package: register map, field layout, reset values and states for the startup/trip block
package lpst_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RESERVED_SLOT = 8'hBA;
    localparam logic [7:0] OFF_STARTUP_STEP = 8'hBB;
    localparam logic [7:0] OFF_TXP_HIGH_ADJ = 8'hBC;
    localparam logic [7:0] OFF_TXP_LOW_ADJ = 8'hBD;
    localparam logic [7:0] OFF_LOS_HIGH_THR = 8'hBE;
    localparam logic [7:0] OFF_LOS_LOW_THR = 8'hBF;
    localparam logic [7:0] OFF_CONTROL = 8'hC8;
    localparam logic [7:0] OFF_STATUS = 8'hC9;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hCA;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hCB;
    localparam logic [7:0] OFF_CURRENT_CEIL = 8'hCC;
    localparam logic [7:0] OFF_POWER_REF = 8'hCD;
    localparam logic [7:0] OFF_BIAS_LOW = 8'hCE;
    localparam logic [7:0] OFF_BIAS_HIGH = 8'hCF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [8:0] RST_CEILING = 9'h1FF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Control: bit 0 = user level, bit 1 = owner level, bit 2 = read grant,
    // bit 3 = read-write grant, bit 4 = transmit disable
    localparam int CTL_USER = 0;
    localparam int CTL_OWNER = 1;
    localparam int CTL_RGRANT = 2;
    localparam int CTL_RWGRANT = 3;
    localparam int CTL_TXDIS = 4;
    // Interrupt status bits; the status register holds flags 0-4 one bit higher
    localparam int ST_TX_POWER_HIGH_FLAG = 0;
    localparam int ST_TX_POWER_LOW_FLAG = 1;
    localparam int ST_SIGNAL_LOSS_LOW_FLAG = 2;
    localparam int ST_SIGNAL_LOSS_HIGH_FLAG = 3;
    localparam int ST_CEIL = 4;
    localparam int ST_DONE = 5;
    localparam int ST_DENIED = 6;
    localparam int NUM_EVT = 7;

    // Code limits for the trip thresholds
    localparam logic [7:0] CODE_MAX = 8'hFF;
    localparam logic [7:0] CODE_MIN = 8'h00;

    // Startup sequencer states
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_STEP = 2'b01,
        SEQ_SEARCH = 2'b10,
        SEQ_RUN = 2'b11
    } lpst_seq_e;

endpackage

// File: sim/lpst_feedback_model.sv
// Behavioural model of the feedback comparator and received signal monitor
`timescale 1ns/1ps

module lpst_feedback_model
(
    input wire logic core_clk, // Clock
    input wire logic [8:0] laserCurrentSetting, // Bias from the block
    input wire logic [9:0] tripBias, // Bias where power crosses threshold
    input wire logic slow, // Adds one cycle of comparator lag
    input wire logic [7:0] powerLevel, // Feedback code to report
    input wire logic [7:0] rxLevel, // Received level to report
    output logic powerFeedbackAbove, // Comparator result
    output logic [7:0] powerFeedbackCode, // Feedback code
    output logic [7:0] receivedSignalLevel // Received level code
);
    logic nowAbove;
    logic lagAbove_ff;

    // Optical power rises with bias; comparator trips at tripBias
    assign nowAbove = {1'b0, laserCurrentSetting} >= tripBias;

    // Lagged copy: a slow comparator, which spoils a fast search result
    always_ff @(posedge core_clk)
    begin
        lagAbove_ff <= nowAbove;
    end

    assign powerFeedbackAbove = slow ? lagAbove_ff : nowAbove;
    assign powerFeedbackCode = powerLevel;
    assign receivedSignalLevel = rxLevel;
endmodule

// File: sim/lpst_props.sv
// Port assertions for the startup and trip block
`timescale 1ns/1ps

module lpst_checker
#(
    parameter int BIAS_W = 9 // Bias width
)
(
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic [7:0] regAddr, // Address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic powerFeedbackAbove, // Comparator
    input wire logic [7:0] powerFeedbackCode, // Feedback code
    input wire logic [7:0] receivedSignalLevel, // Received level
    input wire logic [7:0] regRdata, // Read data
    input wire logic [BIAS_W-1:0] laserCurrentSetting, // Bias
    input wire logic startupDone, // Done
    input wire logic txPowerHighFlag, // High power
    input wire logic txPowerLowFlag, // Low power
    input wire logic signalLossLowFlag, // Loss low
    input wire logic signalLossHighFlag, // Loss high
    input wire logic currentCeilingAlarm, // Ceiling alarm
    input wire logic irq // Interrupt
);
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // Read data only in the cycle after a read strobe
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside its slot");
    // Ceiling alarm only once the search has finished
    a_ceil_gated: assert property (currentCeilingAlarm |-> $past(startupDone))
        else $error("ceiling alarm before search end");
    a_ceil_at_done: assert property ($rose(startupDone) |-> !currentCeilingAlarm)
        else $error("ceiling alarm at search end");
    a_los_exclusive: assert property (!(signalLossLowFlag && signalLossHighFlag))
        else $error("both loss flags set");
    a_los_handover: assert property ($fell(signalLossLowFlag) |-> signalLossHighFlag)
        else $error("loss low cleared without high");
    a_los_from_low: assert property ($rose(signalLossHighFlag) |-> $past(signalLossLowFlag))
        else $error("loss high set without low");
    // Power high and power low alarms never set together
    a_txp_exclusive: assert property (!(txPowerHighFlag && txPowerLowFlag))
        else $error("both power alarms set");
    a_tx_power_high_flag_floor: assert property ($past(powerFeedbackCode) == 8'h00 |-> !txPowerHighFlag)
        else $error("power high at zero code");
    a_tx_power_low_flag_top: assert property ($past(powerFeedbackCode) == 8'hFF |-> !txPowerLowFlag)
        else $error("power low at full code");
endmodule

bind lpst_laser_power_startup_trip lpst_checker #(.BIAS_W(BIAS_W)) i_lpst_checker
(
    .core_clk(core_clk),
    .srst(srst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .powerFeedbackAbove(powerFeedbackAbove),
    .powerFeedbackCode(powerFeedbackCode),
    .receivedSignalLevel(receivedSignalLevel),
    .regRdata(regRdata),
    .laserCurrentSetting(laserCurrentSetting),
    .startupDone(startupDone),
    .txPowerHighFlag(txPowerHighFlag),
    .txPowerLowFlag(txPowerLowFlag),
    .signalLossLowFlag(signalLossLowFlag),
    .signalLossHighFlag(signalLossHighFlag),
    .currentCeilingAlarm(currentCeilingAlarm),
    .irq(irq)
);

// File: sim/lpst_laser_power_startup_trip_bench.sv
// Self-checking bench for startup search, power trips and loss flags
`timescale 1ns/1ps

module lpst_laser_power_startup_trip_bench;
    import lpst_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [9:0] tripBias = 10'h020;
    logic slow = 1'b0;
    logic [7:0] powerLevel = 8'h80;
    logic [7:0] rxLevel = 8'h90;
    logic powerFeedbackAbove;
    logic [7:0] powerFeedbackCode;
    logic [7:0] receivedSignalLevel;
    logic [7:0] regRdata;
    logic [8:0] bias;
    logic done;
    logic txHi;
    logic txLo;
    logic losLo;
    logic losHi;
    logic ceilAlarm;
    logic irq;
    int fail_count = 0;
    int checks = 0;

    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #4 core_clk = ~core_clk;

    lpst_laser_power_startup_trip #(.BIAS_W(9)) i_lpst_laser_power_startup_trip
    (
        .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .powerFeedbackAbove(powerFeedbackAbove),
        .powerFeedbackCode(powerFeedbackCode), .receivedSignalLevel(receivedSignalLevel),
        .regRdata(regRdata), .laserCurrentSetting(bias), .startupDone(done),
        .txPowerHighFlag(txHi), .txPowerLowFlag(txLo), .signalLossLowFlag(losLo),
        .signalLossHighFlag(losHi), .currentCeilingAlarm(ceilAlarm), .irq(irq)
    );

    lpst_feedback_model i_lpst_feedback_model
    (
        .core_clk(core_clk), .laserCurrentSetting(bias), .tripBias(tripBias),
        .slow(slow), .powerLevel(powerLevel), .rxLevel(rxLevel),
        .powerFeedbackAbove(powerFeedbackAbove), .powerFeedbackCode(powerFeedbackCode),
        .receivedSignalLevel(receivedSignalLevel)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Settle one past the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 2000 && done !== 1'b1; i++)
            cyc(1);
        if (done !== 1'b1)
        begin
            fail_count++;
            $display("unexpected startupDone: expected 1 seen %b", done);
            final_report();
        end
    endtask

    // Transmit-disable pulse with a new step size
    task automatic restart(input logic [7:0] s);
        wr(OFF_CONTROL, 8'h12);
        wr(OFF_STARTUP_STEP, s);
        wr(OFF_CONTROL, 8'h02);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_access();
        logic [7:0] v;
        logic [7:0] ctl [4] = '{8'h00, 8'h05, 8'h09, 8'h02};
        logic [3:0] rok = 4'b1110;
        logic [3:0] wok = 4'b1100;
        int i;
        for (i = 0; i < 6; i++)
        begin
            rd(OFF_RESERVED_SLOT + 8'(i), v);
            check("resetValue", v, RST_REG8);
        end
        rd(OFF_CURRENT_CEIL, v);
        check("ceilReset", v, 8'hFF);
        wr(OFF_RESERVED_SLOT, 8'h5A);
        rd(OFF_RESERVED_SLOT, v);
        check("reserved", v, 8'h00);
        rd(8'h10, v);
        check("unmapped", v, 8'h00);
        // Each privilege mix: refused writes keep the old value, refused reads give 0
        for (i = 0; i < 4; i++)
        begin
            wr(OFF_CONTROL, 8'h02);
            wr(OFF_TXP_HIGH_ADJ, 8'hA0);
            wr(OFF_CONTROL, ctl[i]);
            wr(OFF_TXP_HIGH_ADJ, 8'h50 + 8'(i));
            rd(OFF_TXP_HIGH_ADJ, v);
            check("grant", v, rok[i] ? (wok[i] ? 8'h50 + 8'(i) : 8'hA0) : 8'h00);
        end
        rd(OFF_IRQ_STATUS, v);
        check("denied", v[ST_DENIED], 1'b1);
        wr(OFF_TXP_HIGH_ADJ, 8'h00);
    endtask

    // Adjusts written in the same 8-bit code scale as the reference
    task automatic trip(input logic [7:0] r, input logic [7:0] h, input logic [7:0] l,
                        input logic [7:0] c);
        logic [8:0] hs;
        logic [7:0] ht;
        logic [7:0] lt;
        hs = {1'b0, r} + {1'b0, h};
        ht = hs[8] ? 8'hFF : hs[7:0];
        lt = (l > r) ? 8'h00 : r - l;
        wr(OFF_POWER_REF, r);
        wr(OFF_TXP_HIGH_ADJ, h);
        wr(OFF_TXP_LOW_ADJ, l);
        powerLevel <= c;
        cyc(4);
        check("txHigh", txHi, c > ht);
        check("txLow", txLo, c < lt);
    endtask

    task automatic t_trips();
        trip(8'hF0, 8'h20, 8'h00, 8'hFF);
        trip(8'h80, 8'h10, 8'h10, 8'h91);
        trip(8'h80, 8'h10, 8'h10, 8'h90);
        trip(8'h80, 8'h10, 8'h10, 8'h6F);
        trip(8'h80, 8'h10, 8'h10, 8'h70);
        trip(8'h10, 8'h00, 8'h20, 8'h00);
    endtask

    // Feedback never trips, so the search lands above a lowered ceiling
    task automatic t_ceiling();
        logic [8:0] prev;
        int i;
        wr(OFF_CURRENT_CEIL, 8'h10);
        tripBias <= 10'h3FF;
        slow <= 1'b1;
        restart(8'h03);
        prev = bias;
        for (i = 0; i < 400 && done !== 1'b1; i++)
        begin
            cyc(1);
            if (bias == prev + 9'h007)
                check("stepCap", bias > 9'h021, 1'b0);
            check("ceilQuiet", ceilAlarm, 1'b0);
            prev = bias;
        end
        wait_done();
        cyc(3);
        check("ceilAlarm", ceilAlarm, 1'b1);
        wr(OFF_CURRENT_CEIL, 8'hFF);
        slow <= 1'b0;
    endtask

    task automatic t_startup();
        logic [8:0] a;
        logic [7:0] v;
        tripBias <= 10'h0C5;
        restart(8'h03);
        cyc(4);
        a = bias;
        cyc(1);
        check("step", bias - a, 16'h0007);
        wait_done();
        check("searchEnd", bias, 9'h0C4);
        check("ceilOff", ceilAlarm, 1'b0);
        rd(OFF_BIAS_LOW, v);
        check("biasLow", v, 8'hC4);
        rd(OFF_STATUS, v);
        check("statusDone", v[0], 1'b1);
    endtask

    task automatic los(input logic [7:0] lv, input logic el, input logic eh, input logic ei);
        @(posedge core_clk);
        rxLevel <= lv;
        cyc(4);
        check("lossLow", losLo, el);
        check("lossHigh", losHi, eh);
        check("irq", irq, ei);
    endtask

    task automatic t_los();
        logic [7:0] v;
        wr(OFF_LOS_LOW_THR, 8'h40);
        wr(OFF_LOS_HIGH_THR, 8'h80);
        rd(OFF_IRQ_STATUS, v);
        wr(OFF_IRQ_MASK, 8'h04);
        los(8'h30, 1'b1, 1'b0, 1'b1);
        los(8'h60, 1'b1, 1'b0, 1'b1);
        rd(OFF_IRQ_STATUS, v);
        check("lossEvent", v[ST_SIGNAL_LOSS_LOW_FLAG], 1'b1);
        los(8'h90, 1'b0, 1'b1, 1'b0);
        wr(OFF_IRQ_MASK, 8'h00);
        los(8'h30, 1'b1, 1'b0, 1'b0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        cyc(1);
        check("lossLowReset", losLo, 1'b0);
        check("lossHighReset", losHi, 1'b0);
        wait_done();
        check("powerOnSearch", bias, 9'h01F);
        wr(OFF_CONTROL, 8'h02);
        t_access();
        t_trips();
        t_ceiling();
        t_startup();
        t_los();
        final_report();
    end
endmodule
